// *** rtl/alu_condition_flags_status_word.sv ***
// Contract
// - Negative flag copies result MSB, bit 15 word or bit 7 byte.
// - One-operand bit op: N prior bit, Z inverse, C and V cleared.
// - Two-operand bit op: N xor, C and, V or, Z nor.
// - Addition sets carry from carry out of selected MSB.
// - Subtract and compare: carry is borrow, inverse of carry out.
// - Logical, multiply and divide clear carry.
// - Shifts load carry with last bit out; zero count clears it.
// - Prioritize clears carry; zero means second operand was zero.
// - Add, subtract, negate set overflow on signed range exit.
// - Multiply/divide overflow when not fitting word; divide by zero too.
// - Logical operations clear overflow.
// - Right shifts use overflow as sticky bit of earlier lost ones.
// - Zero flag set when result equals zero.
// - With-carry add/subtract keep zero only if already set.
// - End-of-table set when source is most negative value.
// - Interrupted flag shows an unfinished multiply or divide.
// - Explicit status word write overrides implicit flag update.
// - Read returns status word after preceding instruction.
// - Reset clears all ALU status bits.
// - User flag freely written by software, never by hardware; return from service also reloads it from the stacked word.
// - Interrupt enable and four-bit level; reset disabled, level 0.
// - Service entry sets interrupted flag if multiply/divide pending; return restores from stack.
// - Reserved bits ignore writes and read zero.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module alu_condition_flags_status_word
	import stw_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	input  wire logic        alu_valid,
	input  wire alu_op_t     alu_op,
	input  wire logic        byte_op,
	input  wire logic [15:0] opnd_a,
	input  wire logic [15:0] opnd_b,
	input  wire logic [15:0] result,
	input  wire logic        carry_out_w,
	input  wire logic        carry_out_b,
	input  wire logic        muldiv_ovf,
	input  wire logic        div_by_zero,
	input  wire logic [4:0]  shift_cnt,
	input  wire logic        last_out,
	input  wire logic        sticky_out,
	input  wire logic        bit_a,
	input  wire logic        bit_b,
	input  wire logic        isr_entry,
	input  wire logic [3:0]  isr_level,
	input  wire logic        muldiv_pending,
	input  wire logic        reti,
	input  wire logic [15:0] stacked_stw,
	output logic [15:0]      processor_status_word,
	output logic             global_irq_enable,
	output logic [3:0]       cpu_priority_level,
	output logic             muldiv_interrupted_flag,
	output logic             user_general_flag
);
	// ****************************************************
	// Flag generation
	// ****************************************************
	flag_bus_if fb ();
	logic [4:0] cond_q;
	logic [4:0] cond_d;
	logic       mdint_q;
	logic       mdint_d;
	logic       user_q;
	logic       user_d;
	logic [3:0] level_q;
	logic       irq_en_q;
	logic       stw_hit;
	logic       sw_wr;
	logic       irq_wr;
	logic [15:0] stw_view;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic [15:0] stw_out_q;
	upd_state_t  state_q;
	upd_state_t  state_d;

	flag_calc u_calc (
		.alu_valid   (alu_valid),
		.alu_op      (alu_op),
		.byte_op     (byte_op),
		.opnd_a      (opnd_a),
		.opnd_b      (opnd_b),
		.result      (result),
		.carry_out_w (carry_out_w),
		.carry_out_b (carry_out_b),
		.muldiv_ovf  (muldiv_ovf),
		.div_by_zero (div_by_zero),
		.shift_cnt   (shift_cnt),
		.last_out    (last_out),
		.sticky_out  (sticky_out),
		.bit_a       (bit_a),
		.bit_b       (bit_b),
		.zero_prev   (cond_q[flag_zero]),
		.fo          (fb.src)
	);

	// ****************************************************
	// Interrupt control fields
	// ****************************************************
	// Reti restores the whole word, including level and enable
	assign irq_wr = sw_wr || reti;

	irq_status u_irq (
		.clk       (clk),
		.nrst      (nrst),
		.sw_wr     (irq_wr),
		.sw_val    (sw_wr ? {reg_wdata[15:12], reg_wdata[flag_irq_en]}
		                  : {stacked_stw[15:12], stacked_stw[flag_irq_en]}),
		.isr_entry (isr_entry),
		.isr_level (isr_level),
		.level_q   (level_q),
		.irq_en_q  (irq_en_q)
	);

	// ****************************************************
	// Status word update
	// ****************************************************
	always_comb begin
		stw_hit = (reg_addr == stw_addr);
		sw_wr   = reg_wr && stw_hit;
	end

	always_comb begin
		cond_d  = cond_q;
		mdint_d = mdint_q;
		user_d  = user_q;
		state_d = st_idle;
		// Software write supersedes the hardware update of the same cycle
		if (sw_wr) begin
			cond_d  = reg_wdata[4:0];
			mdint_d = reg_wdata[flag_muldiv];
			user_d  = reg_wdata[flag_user];
			state_d = st_hold;
		end else begin
			if (reti) begin
				cond_d  = stacked_stw[4:0];
				mdint_d = stacked_stw[flag_muldiv];
				user_d  = stacked_stw[flag_user];
				state_d = st_update;
			end else if (fb.valid) begin
				cond_d[flag_neg]   = fb.neg;
				cond_d[flag_carry] = fb.carry;
				cond_d[flag_ovf]   = fb.ovf;
				cond_d[flag_zero]  = fb.zero;
				cond_d[flag_eot]   = fb.eot;
				state_d = st_update;
			end
			if (isr_entry && muldiv_pending) begin
				mdint_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cond_q  <= 5'h00;
			mdint_q <= 1'b0;
			user_q  <= 1'b0;
			state_q <= st_idle;
		end else begin
			cond_q  <= cond_d;
			mdint_q <= mdint_d;
			user_q  <= user_d;
			state_q <= state_d;
		end
	end

	// ****************************************************
	// Register read and outputs
	// ****************************************************
	always_comb begin
		stw_view = {level_q, irq_en_q, 4'h0, user_q, mdint_q, cond_q};
		stw_view = stw_view & stw_impl_mask;
		rdata_d  = 16'h0000;
		// Reads see the word as left by the previous instruction
		if (reg_rd && stw_hit) begin
			rdata_d = stw_view;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_q   <= stw_reset;
			stw_out_q <= stw_reset;
		end else begin
			rdata_q   <= rdata_d;
			stw_out_q <= {level_d_view(), stw_view[11:0]};
		end
	end

	function automatic logic [3:0] level_d_view();
		level_d_view = level_q;
	endfunction

	assign reg_rdata               = rdata_q;
	assign processor_status_word   = stw_out_q;
	assign global_irq_enable       = irq_en_q;
	assign cpu_priority_level      = level_q;
	assign muldiv_interrupted_flag = mdint_q;
	assign user_general_flag       = user_q;
endmodule

// *** rtl/psw_pkg.sv ***
package stw_pkg;
	// ****************************************************
	// Register map and field layout
	// ****************************************************
	localparam logic [15:0] stw_addr      = 16'hff10;
	localparam int          flag_neg      = 0;
	localparam int          flag_carry    = 1;
	localparam int          flag_ovf      = 2;
	localparam int          flag_zero     = 3;
	localparam int          flag_eot      = 4;
	localparam int          flag_muldiv   = 5;
	localparam int          flag_user     = 6;
	localparam int          flag_irq_en   = 11;
	localparam int          lvl_lsb       = 12;
	localparam logic [15:0] stw_impl_mask = 16'hf87f;
	localparam logic [15:0] stw_reset     = 16'h0000;
	localparam logic [3:0]  lvl_reset     = 4'h0;
	localparam logic [15:0] word_min_neg  = 16'h8000;
	localparam logic [7:0]  byte_min_neg  = 8'h80;
	localparam int          word_msb      = 15;
	localparam int          byte_msb      = 7;
	localparam logic [4:0]  shift_none    = 5'h00;

	// ****************************************************
	// Instruction classes driven by the pipeline
	// ****************************************************
	typedef enum logic [3:0] {
		op_none    = 4'h0,
		op_add     = 4'h1,
		op_addc    = 4'h2,
		op_sub     = 4'h3,
		op_subc    = 4'h4,
		op_neg     = 4'h5,
		op_logic   = 4'h6,
		op_muldiv  = 4'h7,
		op_shl     = 4'h8,
		op_shr     = 4'h9,
		op_prior   = 4'ha,
		op_bit1    = 4'hb,
		op_bit2    = 4'hc,
		op_move    = 4'hd
	} alu_op_t;

	typedef enum logic [2:0] {
		st_idle   = 3'b001,
		st_update = 3'b010,
		st_hold   = 3'b100
	} upd_state_t;
endpackage

// *** rtl/flag_bus_if.sv ***
`timescale 1ns/1ps
interface flag_bus_if;
	import stw_pkg::*;
	logic       valid;
	logic       neg;
	logic       carry;
	logic       ovf;
	logic       zero;
	logic       eot;
	modport src (output valid, neg, carry, ovf, zero, eot);
	modport dst (input valid, neg, carry, ovf, zero, eot);
endinterface

// *** rtl/flag_calc.sv ***
`timescale 1ns/1ps
module flag_calc
	import stw_pkg::*;
(
	input  wire logic        alu_valid,
	input  wire alu_op_t     alu_op,
	input  wire logic        byte_op,
	input  wire logic [15:0] opnd_a,
	input  wire logic [15:0] opnd_b,
	input  wire logic [15:0] result,
	input  wire logic        carry_out_w,
	input  wire logic        carry_out_b,
	input  wire logic        muldiv_ovf,
	input  wire logic        div_by_zero,
	input  wire logic [4:0]  shift_cnt,
	input  wire logic        last_out,
	input  wire logic        sticky_out,
	input  wire logic        bit_a,
	input  wire logic        bit_b,
	input  wire logic        zero_prev,
	flag_bus_if.src          fo
);
	logic msb_r;
	logic msb_a;
	logic msb_b;
	logic res_zero;
	logic cout;
	logic add_v;
	logic sub_v;
	logic neg_v;

	always_comb begin
		msb_r    = byte_op ? result[byte_msb] : result[word_msb];
		msb_a    = byte_op ? opnd_a[byte_msb] : opnd_a[word_msb];
		msb_b    = byte_op ? opnd_b[byte_msb] : opnd_b[word_msb];
		res_zero = byte_op ? (result[7:0] == 8'h00) : (result == 16'h0000);
		cout     = byte_op ? carry_out_b : carry_out_w;
		add_v    = (msb_a == msb_b) && (msb_r != msb_a);
		sub_v    = (msb_a != msb_b) && (msb_r != msb_a);
		neg_v    = msb_b && msb_r;
		fo.valid = alu_valid;
		fo.neg   = msb_r;
		fo.carry = 1'b0;
		fo.ovf   = 1'b0;
		fo.zero  = res_zero;
		if (byte_op) begin
			fo.eot = (opnd_b[7:0] == byte_min_neg);
		end else begin
			fo.eot = (opnd_b == word_min_neg);
		end
		case (alu_op)
			op_add, op_addc: begin
				fo.carry = cout;
				fo.ovf   = add_v;
				if (alu_op == op_addc) begin
					fo.zero = zero_prev && res_zero;
				end
			end
			op_sub, op_subc: begin
				fo.carry = ~cout;
				fo.ovf   = sub_v;
				if (alu_op == op_subc) begin
					fo.zero = zero_prev && res_zero;
				end
			end
			op_neg: begin
				fo.carry = ~cout;
				fo.ovf   = neg_v;
			end
			op_logic: begin
				fo.carry = 1'b0;
				fo.ovf   = 1'b0;
			end
			op_muldiv: begin
				fo.carry = 1'b0;
				fo.ovf   = muldiv_ovf || div_by_zero;
			end
			op_shl: begin
				fo.carry = (shift_cnt == shift_none) ? 1'b0 : last_out;
			end
			op_shr: begin
				fo.carry = (shift_cnt == shift_none) ? 1'b0 : last_out;
				fo.ovf   = (shift_cnt == shift_none) ? 1'b0 : sticky_out;
			end
			op_prior: begin
				fo.carry = 1'b0;
				fo.zero  = byte_op ? (opnd_b[7:0] == 8'h00)
				                   : (opnd_b == 16'h0000);
			end
			op_bit1: begin
				fo.neg   = bit_a;
				fo.zero  = ~bit_a;
				fo.carry = 1'b0;
				fo.ovf   = 1'b0;
			end
			op_bit2: begin
				fo.neg   = bit_a ^ bit_b;
				fo.carry = bit_a & bit_b;
				fo.ovf   = bit_a | bit_b;
				fo.zero  = ~(bit_a | bit_b);
			end
			default: begin
				fo.carry = 1'b0;
			end
		endcase
	end
endmodule

// *** rtl/irq_status.sv ***
`timescale 1ns/1ps
module irq_status
	import stw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       sw_wr,
	input  wire logic [4:0] sw_val,
	input  wire logic       isr_entry,
	input  wire logic [3:0] isr_level,
	output logic [3:0]      level_q,
	output logic            irq_en_q
);
	logic [3:0] level_d;
	logic       irq_en_d;

	always_comb begin
		level_d = level_q;
		irq_en_d = irq_en_q;
		if (sw_wr) begin
			level_d = sw_val[4:1];
			irq_en_d = sw_val[0];
		end else if (isr_entry) begin
			level_d = isr_level;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			level_q <= lvl_reset;
			irq_en_q <= 1'b0;
		end else begin
			level_q <= level_d;
			irq_en_q <= irq_en_d;
		end
	end
endmodule

// *** verif/psw_asserts.sv ***
`timescale 1ns/1ps
module stw_asserts
	import stw_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        alu_valid,
	input wire alu_op_t     alu_op,
	input wire logic        byte_op,
	input wire logic [15:0] result,
	input wire logic        isr_entry,
	input wire logic [3:0]  isr_level,
	input wire logic        muldiv_pending,
	input wire logic        reti,
	input wire logic [15:0] stacked_stw,
	input wire logic [15:0] processor_status_word,
	input wire logic        global_irq_enable,
	input wire logic [3:0]  cpu_priority_level,
	input wire logic        muldiv_interrupted_flag,
	input wire logic        user_general_flag
);
	// ********
	// Checks
	// ********
	logic sw_wr;
	assign sw_wr = reg_wr && reg_addr == stw_addr;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Word copy lags the flags, so logic results land two edges on
	sequence logic_done;
		alu_valid && alu_op == op_logic && !byte_op && !sw_wr && !reti;
	endsequence
	AST_RST_CLEAR: assert property ($past(!nrst) |->
		processor_status_word == stw_reset &&
		cpu_priority_level == lvl_reset && !global_irq_enable)
		else $error("status not cleared by reset");
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |->
		reg_rdata == 16'h0000) else $error("read data outside read");
	AST_RSVD_ZERO: assert property (reg_rdata[10:7] == 4'h0 &&
		processor_status_word[10:7] == 4'h0) else $error("reserved set");
	AST_SW_WR: assert property (sw_wr |=>
		user_general_flag == $past(reg_wdata[flag_user]) &&
		global_irq_enable == $past(reg_wdata[flag_irq_en]) &&
		cpu_priority_level == $past(reg_wdata[15:12]) &&
		muldiv_interrupted_flag == $past(reg_wdata[flag_muldiv]))
		else $error("write not taken");
	AST_SW_WORD: assert property (sw_wr |=> ##1
		processor_status_word == ($past(reg_wdata, 2) & stw_impl_mask))
		else $error("written word not shown");
	AST_LOGIC: assert property (logic_done |=> ##1
		!processor_status_word[flag_carry] &&
		!processor_status_word[flag_ovf] &&
		processor_status_word[flag_neg] == $past(result[word_msb], 2) &&
		processor_status_word[flag_zero] == ($past(result, 2) == 16'h0000))
		else $error("logic flags wrong");
	AST_USER_HOLD: assert property ($past(nrst) && !$past(sw_wr) &&
		!$past(reti) |-> $stable(user_general_flag))
		else $error("user flag moved");
	AST_ISR_LVL: assert property (isr_entry && !sw_wr && !reti |=>
		cpu_priority_level == $past(isr_level)) else $error("level");
	AST_ISR_MUL: assert property (isr_entry && muldiv_pending &&
		!sw_wr |=> muldiv_interrupted_flag) else $error("not flagged");
	AST_RETI: assert property (reti && !sw_wr && !isr_entry |=>
		muldiv_interrupted_flag == $past(stacked_stw[flag_muldiv]) &&
		user_general_flag == $past(stacked_stw[flag_user]))
		else $error("return restore wrong");
	AST_MUL_HOLD: assert property ($rose(muldiv_interrupted_flag) &&
		$past(nrst) |-> $past(isr_entry && muldiv_pending || sw_wr || reti))
		else $error("interrupted flag rose alone");
endmodule
bind alu_condition_flags_status_word stw_asserts u_chk (
	.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.alu_valid, .alu_op, .byte_op, .result, .isr_entry, .isr_level,
	.muldiv_pending, .reti, .stacked_stw, .processor_status_word,
	.global_irq_enable, .cpu_priority_level, .muldiv_interrupted_flag,
	.user_general_flag
);

// *** verif/alu_model.sv ***
`timescale 1ns/1ps
module alu_model
	import stw_pkg::*;
(
	input  wire alu_op_t     op,
	input  wire logic [15:0] a,
	input  wire logic [15:0] b,
	output logic [15:0]      res,
	output logic             cw,
	output logic             cb
);
	// ********
	// Shared adder
	// ********
	// Incoming carry of with-carry ops is ignored: zero chaining only
	logic        sub;
	logic [15:0] aa;
	logic [15:0] bb;
	logic [16:0] sum;
	logic [8:0]  low;
	always_comb begin
		sub = op inside {op_sub, op_subc, op_neg};
		aa  = (op == op_neg) ? 16'h0000 : a;
		bb  = sub ? ~b : b;
		sum = {1'b0, aa} + {1'b0, bb} + {16'h0000, sub};
		low = {1'b0, aa[7:0]} + {1'b0, bb[7:0]} + {8'h00, sub};
		cw  = sum[16];
		cb  = low[8];
		case (op)
			op_logic: res = a & b;
			op_move:  res = b;
			op_muldiv, op_shl, op_shr, op_prior, op_bit1, op_bit2: res = a;
			default:  res = sum[15:0];
		endcase
	end
endmodule

// *** verif/alu_condition_flags_status_word_tb.sv ***
`timescale 1ns/1ps
module alu_condition_flags_status_word_tb;
	import stw_pkg::*;
	logic        clk;
	logic        nrst;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        alu_valid;
	alu_op_t     alu_op;
	logic        byte_op;
	logic [15:0] opnd_a;
	logic [15:0] opnd_b;
	logic [15:0] result;
	logic        carry_out_w;
	logic        carry_out_b;
	logic [4:0]  shift_cnt;
	logic [5:0]  side;
	logic        isr_entry;
	logic [3:0]  isr_level;
	logic        muldiv_pending;
	logic        reti;
	logic [15:0] stacked_stw;
	logic [15:0] processor_status_word;
	logic        global_irq_enable;
	logic [3:0]  cpu_priority_level;
	logic        muldiv_interrupted_flag;
	logic        user_general_flag;
	int          failures;
	int          samples_checked;
	alu_model u_alu (.op(alu_op), .a(opnd_a), .b(opnd_b), .res(result),
		.cw(carry_out_w), .cb(carry_out_b));
	alu_condition_flags_status_word uut (
		.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.alu_valid, .alu_op, .byte_op, .opnd_a, .opnd_b, .result,
		.carry_out_w, .carry_out_b, .muldiv_ovf(side[4]),
		.div_by_zero(side[5]), .shift_cnt, .last_out(side[3]),
		.sticky_out(side[2]), .bit_a(side[1]), .bit_b(side[0]),
		.isr_entry, .isr_level, .muldiv_pending, .reti, .stacked_stw,
		.processor_status_word, .global_irq_enable, .cpu_priority_level,
		.muldiv_interrupted_flag, .user_general_flag
	);
	// ********
	// Access tasks
	// ********
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, m, e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata & m, e);
	endtask
	task automatic alu(input alu_op_t o, input logic b8,
		input logic [15:0] a, b, input logic [4:0] sc, input logic [5:0] s);
		@(posedge clk);
		alu_valid <= 1'b1;
		alu_op    <= o;
		byte_op   <= b8;
		opnd_a    <= a;
		opnd_b    <= b;
		shift_cnt <= sc;
		side      <= s;
		@(posedge clk);
		alu_valid <= 1'b0;
	endtask
	// Flags read back as {E,Z,V,C,N} under a mask
	task automatic af(input alu_op_t o, input logic b8,
		input logic [15:0] a, b, input logic [4:0] sc, input logic [5:0] s,
		input logic [4:0] m, e);
		alu(o, b8, a, b, sc, s);
		rd(stw_addr, {11'h000, m}, {11'h000, e});
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ********
	// Clock, watchdog, tests
	// ********
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		finish_test();
	end
	initial begin
		logic [1:0] k;
		{nrst, reg_addr, reg_wdata, reg_wr, reg_rd, alu_valid} = '0;
		{byte_op, opnd_a, opnd_b, shift_cnt, side} = '0;
		{isr_entry, isr_level, muldiv_pending, reti, stacked_stw} = '0;
		alu_op = op_none;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(stw_addr, 16'hffff, stw_reset);
		wr(stw_addr, 16'hffff);
		rd(stw_addr, 16'hffff, stw_impl_mask);
		rd(16'hff12, 16'hffff, 16'h0000);
		af(op_add, 1'b0, 16'h7fff, 16'h0001, 5'h00, 6'h00,
			5'h1f, 5'h05);
		af(op_add, 1'b0, 16'hffff, 16'h0001, 5'h00, 6'h00,
			5'h1f, 5'h0a);
		af(op_add, 1'b1, 16'h00ff, 16'h0001, 5'h00, 6'h00,
			5'h1f, 5'h0a);
		af(op_add, 1'b1, 16'h007f, 16'h0001, 5'h00, 6'h00,
			5'h1f, 5'h05);
		af(op_sub, 1'b0, 16'h0000, 16'h0001, 5'h00, 6'h00,
			5'h1f, 5'h03);
		af(op_sub, 1'b0, 16'h8000, 16'h0001, 5'h00, 6'h00,
			5'h1f, 5'h04);
		af(op_neg, 1'b0, 16'h0000, 16'h8000, 5'h00, 6'h00,
			5'h05, 5'h05);
		af(op_logic, 1'b0, 16'hffff, 16'h8000, 5'h00, 6'h18,
			5'h0f, 5'h01);
		af(op_move, 1'b0, 16'h0000, 16'h8000, 5'h00, 6'h00,
			5'h10, 5'h10);
		af(op_move, 1'b1, 16'h0000, 16'h0080, 5'h00, 6'h00,
			5'h10, 5'h10);
		af(op_move, 1'b0, 16'h0000, 16'h8001, 5'h00, 6'h00,
			5'h10, 5'h00);
		af(op_muldiv, 1'b0, 16'h0001, 16'h0003, 5'h00, 6'h10,
			5'h07, 5'h04);
		af(op_muldiv, 1'b0, 16'h0001, 16'h0000, 5'h00, 6'h20,
			5'h07, 5'h04);
		af(op_muldiv, 1'b0, 16'h0001, 16'h0003, 5'h00, 6'h00,
			5'h07, 5'h00);
		af(op_shl, 1'b0, 16'h0008, 16'h0000, 5'h03, 6'h08,
			5'h0b, 5'h02);
		af(op_shl, 1'b0, 16'h0008, 16'h0000, shift_none, 6'h08,
			5'h0b, 5'h00);
		af(op_shr, 1'b0, 16'h0000, 16'h0000, 5'h04, 6'h04,
			5'h0f, 5'h0c);
		af(op_shr, 1'b0, 16'h0001, 16'h0000, 5'h04, 6'h08,
			5'h0f, 5'h02);
		af(op_prior, 1'b0, 16'h0004, 16'h0000, 5'h00, 6'h00,
			5'h0a, 5'h08);
		af(op_prior, 1'b0, 16'h0000, 16'h1234, 5'h00, 6'h00,
			5'h0a, 5'h00);
		af(op_bit1, 1'b0, 16'h0000, 16'h0000, 5'h00, 6'h02,
			5'h0f, 5'h01);
		af(op_bit1, 1'b0, 16'h0001, 16'h0000, 5'h00, 6'h00,
			5'h0f, 5'h08);
		for (int i = 0; i < 4; i++) begin
			k = i[1:0];
			af(op_bit2, 1'b0, 16'h0000, 16'h0000, 5'h00, {4'h0, k}, 5'h0f,
				{1'b0, ~|k, |k, &k, ^k});
		end
		wr(stw_addr, 16'h0000);
		af(op_addc, 1'b0, 16'h0000, 16'h0000, 5'h00, 6'h00,
			5'h08, 5'h00);
		af(op_add, 1'b0, 16'hffff, 16'h0001, 5'h00, 6'h00,
			5'h08, 5'h08);
		af(op_addc, 1'b0, 16'h0000, 16'h0000, 5'h00, 6'h00,
			5'h08, 5'h08);
		af(op_subc, 1'b0, 16'h0001, 16'h0000, 5'h00, 6'h00,
			5'h08, 5'h00);
		// Write lands in the same cycle as a completing add
		fork
			alu(op_add, 1'b0, 16'h7fff, 16'h0001, 5'h00, 6'h00);
			wr(stw_addr, 16'h0048);
		join
		rd(stw_addr, 16'hffff, 16'h0048);
		@(posedge clk);
		isr_entry      <= 1'b1;
		isr_level      <= 4'h9;
		muldiv_pending <= 1'b1;
		@(posedge clk);
		isr_entry      <= 1'b0;
		muldiv_pending <= 1'b0;
		rd(stw_addr, 16'hf860, 16'h9060);
		@(posedge clk);
		reti <= 1'b1;
		@(posedge clk);
		reti <= 1'b0;
		rd(stw_addr, 16'h0060, 16'h0000);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(stw_addr, 16'hffff, stw_reset);
		finish_test();
	end
endmodule
